// file: logic/bmr_core.sv
// Banked register file, status words and configuration of the core
//
// How it works
// - Program counter is its own full 32-bit register.
// - Flags, masks and mode live in a separate current status word.
// - In full configuration each privileged mode has a saved status word for the previous status.
// - Abort and illegal-opcode modes own private stack and link registers.
// - Configuration register selects one of three configurations.
// - Narrow configuration uses a 26-bit address space.
// - Narrow configuration allows only 26-bit modes; 32-bit selections do nothing.
// - Reset selects the narrow configuration.
// - Mixed configuration acts narrow but raises no address exceptions.
// - Full configuration lets software select any 26-bit or 32-bit mode.
// - Full configuration offers ten modes including abort and illegal-opcode.
// - Data or prefetch aborts enter abort mode in full configuration, 26-bit supervisor mode otherwise.
// - Undefined instructions enter illegal-opcode mode in full configuration, 26-bit supervisor mode otherwise.
// - Address exceptions arise only in the narrow configuration.
// - Status read and write instructions keep working in 26-bit modes.
// - In full configuration every exception lands in a 32-bit mode.
// - In 26-bit modes writes to 0 through 1F are blocked with data abort.
// - 26-bit reads of the PC word merge interrupt masks at bits 27, 26.
// - Fast interrupt mode banks registers 8-14; others bank 13 and 14.
// - Full-configuration entry saves PC to link and status to saved word.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module bmr_core (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // General register read ports
  input  wire logic [3:0]          rd_a_idx,
  input  wire logic [3:0]          rd_b_idx,
  output logic      [31:0]         rd_a_q,
  output logic      [31:0]         rd_b_q,
  // General register write port
  input  wire logic                wr_en,
  input  wire logic [3:0]          wr_idx,
  input  wire logic [31:0]         wr_data,
  // Program counter advance
  input  wire logic                pc_wr_en,
  input  wire logic [31:0]         pc_wr_data,
  // Status transfer instructions
  input  wire logic                status_write_instr,
  input  wire logic                status_read_instr,
  input  wire logic                status_use_saved,
  input  wire logic [31:0]         status_wr_data,
  output logic      [31:0]         status_rd_q,
  // Exception entry
  input  wire logic                exc_valid,
  input  wire bmr_pkg::bmr_exc_t   exc_kind,
  input  wire logic [31:0]         exc_ret_pc,
  // Data access check
  input  wire logic                acc_req,
  input  wire logic                acc_write,
  input  wire logic [31:0]         acc_addr,
  output logic                     acc_go_q,
  output logic                     acc_write_q,
  output logic                     acc_addr_exc_q,
  output logic                     acc_vec_abort_q,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata_q,
  // State views
  output logic      [31:0]         pc_q,
  output logic      [31:0]         status_q,
  output logic      [1:0]          config_q
);

  logic [31:0] gpr_q   [bmr_pkg::NUM_PHYS];
  logic [31:0] saved_q [bmr_pkg::NUM_SAVED];
  logic [1:0]  event_q;
  logic [4:0]  mode;
  logic        mode_priv;
  logic [2:0]  cur_bank;
  logic [31:0] pc_word;
  logic [31:0] status_d;
  logic [31:0] pc_d;
  logic [4:0]  exc_mode;
  logic [31:0] exc_vec;
  logic        exc_take;
  logic        cur_saved_ok;

  assign mode = status_q[bmr_pkg::STAT_MODE_HI:bmr_pkg::STAT_MODE_LO];

  // Bank number: 0 user, 1 svc, 2 irq, 3 abt, 4 und, 5 fiq
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    logic [2:0] b;
    b = 3'h0;
    if (m == bmr_pkg::MODE_SVC || m == bmr_pkg::MODE_SVC26) begin
      b = 3'h1;
    end else if (m == bmr_pkg::MODE_IRQ || m == bmr_pkg::MODE_IRQ26) begin
      b = 3'h2;
    end else if (m == bmr_pkg::MODE_ABT) begin
      b = 3'h3;
    end else if (m == bmr_pkg::MODE_UND) begin
      b = 3'h4;
    end else if (m == bmr_pkg::MODE_FIQ || m == bmr_pkg::MODE_FIQ26) begin
      b = 3'h5;
    end
    return b;
  endfunction

  function automatic logic [4:0] phys(input logic [3:0] idx, input logic [4:0] m);
    logic [2:0] b;
    logic [4:0] p;
    b = bank_of(m);
    p = {1'b0, idx};
    if (idx >= 4'h8 && idx <= 4'hc && b == 3'h5) begin
      p = 5'(bmr_pkg::FIQ_BASE) + {1'b0, idx} - 5'h08;
    end else if (idx == 4'hd || idx == 4'he) begin
      // abt and und own 13, 14
      p = 5'(bmr_pkg::BANK_BASE) + {1'b0, b, 1'b0} + {4'h0, idx[0] ^ 1'b1};
    end
    return p;
  endfunction

  // only valid codes; 32-bit ones need the full configuration
  function automatic logic mode_legal(input logic [4:0] m, input logic [1:0] cfg);
    logic ok;
    ok = (m == bmr_pkg::MODE_USR26) || (m == bmr_pkg::MODE_FIQ26) ||
         (m == bmr_pkg::MODE_IRQ26) || (m == bmr_pkg::MODE_SVC26);
    // full configuration opens all ten modes
    if (cfg == bmr_pkg::CFG_FULL) begin
      ok = ok || (m == bmr_pkg::MODE_USR) || (m == bmr_pkg::MODE_FIQ) ||
           (m == bmr_pkg::MODE_IRQ) || (m == bmr_pkg::MODE_SVC) ||
           (m == bmr_pkg::MODE_ABT) || (m == bmr_pkg::MODE_UND);
    end
    return ok;
  endfunction

  // User code may only touch the flags
  function automatic logic [31:0] merge_status(input logic [31:0] cur, input logic [31:0] val,
                                               input logic priv, input logic [1:0] cfg);
    logic [31:0] r;
    r = cur;
    r[bmr_pkg::STAT_FLAGS_HI:bmr_pkg::STAT_FLAGS_LO] =
      val[bmr_pkg::STAT_FLAGS_HI:bmr_pkg::STAT_FLAGS_LO];
    if (priv) begin
      r[bmr_pkg::STAT_IRQ_MASK] = val[bmr_pkg::STAT_IRQ_MASK];
      r[bmr_pkg::STAT_FIQ_MASK] = val[bmr_pkg::STAT_FIQ_MASK];
      if (mode_legal(val[bmr_pkg::STAT_MODE_HI:bmr_pkg::STAT_MODE_LO], cfg)) begin
        r[bmr_pkg::STAT_MODE_HI:bmr_pkg::STAT_MODE_LO] =
          val[bmr_pkg::STAT_MODE_HI:bmr_pkg::STAT_MODE_LO];
      end
    end
    return r;
  endfunction

  assign cur_bank     = bank_of(mode);
  assign mode_priv    = (cur_bank != 3'h0);
  assign cur_saved_ok = mode_priv && (config_q == bmr_pkg::CFG_FULL);

  // combined PC word in 26-bit modes
  always_comb begin
    pc_word = pc_q;
    if (!mode[bmr_pkg::MODE_W32_BIT]) begin
      pc_word = 32'h00000000;
      pc_word[bmr_pkg::STAT_FLAGS_HI:bmr_pkg::STAT_FLAGS_LO] =
        status_q[bmr_pkg::STAT_FLAGS_HI:bmr_pkg::STAT_FLAGS_LO];
      pc_word[bmr_pkg::PCW_IRQ_MASK] = status_q[bmr_pkg::STAT_IRQ_MASK];
      pc_word[bmr_pkg::PCW_FIQ_MASK] = status_q[bmr_pkg::STAT_FIQ_MASK];
      pc_word[bmr_pkg::PCW_PC_HI:bmr_pkg::PCW_PC_LO] =
        pc_q[bmr_pkg::PCW_PC_HI:bmr_pkg::PCW_PC_LO];
      pc_word[1:0] = mode[1:0];
    end
  end

  // Exception target mode and vector
  always_comb begin
    exc_mode = bmr_pkg::MODE_SVC26;
    exc_vec  = bmr_pkg::VEC_SWI;
    exc_take = exc_valid;
    case (exc_kind)
      bmr_pkg::EXC_FIQ: begin
        exc_mode = bmr_pkg::MODE_FIQ26;
        exc_vec  = bmr_pkg::VEC_FIQ;
      end
      bmr_pkg::EXC_IRQ: begin
        exc_mode = bmr_pkg::MODE_IRQ26;
        exc_vec  = bmr_pkg::VEC_IRQ;
      end
      bmr_pkg::EXC_SWI: begin
        exc_mode = bmr_pkg::MODE_SVC26;
        exc_vec  = bmr_pkg::VEC_SWI;
      end
      bmr_pkg::EXC_PABT: begin
        exc_mode = (config_q == bmr_pkg::CFG_FULL) ? bmr_pkg::MODE_ABT : bmr_pkg::MODE_SVC26;
        exc_vec  = bmr_pkg::VEC_PABT;
      end
      bmr_pkg::EXC_DABT: begin
        exc_mode = (config_q == bmr_pkg::CFG_FULL) ? bmr_pkg::MODE_ABT : bmr_pkg::MODE_SVC26;
        exc_vec  = bmr_pkg::VEC_DABT;
      end
      bmr_pkg::EXC_UND: begin
        exc_mode = (config_q == bmr_pkg::CFG_FULL) ? bmr_pkg::MODE_UND : bmr_pkg::MODE_SVC26;
        exc_vec  = bmr_pkg::VEC_UND;
      end
      bmr_pkg::EXC_ADDR: begin
        exc_mode = bmr_pkg::MODE_SVC26;
        exc_vec  = bmr_pkg::VEC_ADDR;
        exc_take = exc_valid && (config_q == bmr_pkg::CFG_NARROW);
      end
      default: begin
        exc_take = 1'b0;
      end
    endcase
    if (config_q == bmr_pkg::CFG_FULL) begin
      exc_mode[bmr_pkg::MODE_W32_BIT] = 1'b1;
    end
  end

  // status word next value; exception beats instruction beats port
  always_comb begin
    status_d = status_q;
    if (exc_take) begin
      status_d[bmr_pkg::STAT_IRQ_MASK] = 1'b1;
      if (exc_kind == bmr_pkg::EXC_FIQ) begin
        status_d[bmr_pkg::STAT_FIQ_MASK] = 1'b1;
      end
      status_d[bmr_pkg::STAT_MODE_HI:bmr_pkg::STAT_MODE_LO] = exc_mode;
    end else if (status_write_instr && !status_use_saved) begin
      status_d = merge_status(status_q, status_wr_data, mode_priv, config_q);
    end else if (reg_wr && reg_addr == bmr_pkg::OFS_STATUS) begin
      status_d = merge_status(status_q, reg_wdata, mode_priv, config_q);
    end
  end

  always_comb begin
    pc_d = pc_q;
    if (exc_take) begin
      pc_d = exc_vec;
    end else if (wr_en && wr_idx == 4'hf) begin
      pc_d = wr_data;
    end else if (pc_wr_en) begin
      pc_d = pc_wr_data;
    end else if (reg_wr && reg_addr == bmr_pkg::OFS_PC) begin
      pc_d = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_q <= bmr_pkg::STAT_RESET;
      pc_q     <= bmr_pkg::PC_RESET;
    end else begin
      status_q <= status_d;
      pc_q     <= pc_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      config_q <= bmr_pkg::CFG_RESET;
    end else if (reg_wr && reg_addr == bmr_pkg::OFS_CONFIG &&
                 reg_wdata[1:0] != 2'h3) begin
      config_q <= reg_wdata[1:0];
    end
  end

  // banked storage, link takes return PC on entry
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < bmr_pkg::NUM_PHYS; i++) begin
        gpr_q[i] <= 32'h00000000;
      end
    end else begin
      if (wr_en && wr_idx != 4'hf) begin
        gpr_q[phys(wr_idx, mode)] <= wr_data;
      end
      if (exc_take) begin
        if (config_q == bmr_pkg::CFG_FULL) begin
          gpr_q[phys(4'he, exc_mode)] <= exc_ret_pc;
        end else begin
          // Narrow and mixed links keep status alongside the PC
          gpr_q[phys(4'he, exc_mode)] <= {pc_word[31:26],
                                          exc_ret_pc[bmr_pkg::PCW_PC_HI:bmr_pkg::PCW_PC_LO],
                                          pc_word[1:0]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < bmr_pkg::NUM_SAVED; i++) begin
        saved_q[i] <= bmr_pkg::STAT_RESET;
      end
    end else if (exc_take && config_q == bmr_pkg::CFG_FULL) begin
      // old status into target's saved word
      saved_q[3'(bank_of(exc_mode) - 3'h1)] <= status_q;
    end else if (status_write_instr && status_use_saved && cur_saved_ok) begin
      saved_q[3'(cur_bank - 3'h1)] <= status_wr_data;
    end else if (reg_wr && reg_addr == bmr_pkg::OFS_SAVED && cur_saved_ok) begin
      saved_q[3'(cur_bank - 3'h1)] <= reg_wdata;
    end
  end

  // Register read ports, one cycle after the index
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rd_a_q <= 32'h00000000;
      rd_b_q <= 32'h00000000;
    end else begin
      rd_a_q <= (rd_a_idx == 4'hf) ? pc_word : gpr_q[phys(rd_a_idx, mode)];
      rd_b_q <= (rd_b_idx == 4'hf) ? pc_word : gpr_q[phys(rd_b_idx, mode)];
    end
  end

  // status read works in every mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      status_rd_q <= 32'h00000000;
    end else if (status_read_instr) begin
      status_rd_q <= (status_use_saved && cur_saved_ok) ?
                     saved_q[3'(cur_bank - 3'h1)] : status_q;
    end
  end

  // Data access check; a blocked store turns into a plain load
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc_go_q        <= 1'b0;
      acc_write_q     <= 1'b0;
      acc_addr_exc_q  <= 1'b0;
      acc_vec_abort_q <= 1'b0;
    end else begin
      acc_go_q        <= acc_req;
      // narrow only, any of the top six bits set
      acc_addr_exc_q  <= acc_req && (config_q == bmr_pkg::CFG_NARROW) &&
                         (acc_addr[31:bmr_pkg::NARROW_ADDR_W] != 6'h00);
      // vector writes in 26-bit modes abort
      acc_vec_abort_q <= acc_req && acc_write && !mode[bmr_pkg::MODE_W32_BIT] &&
                         (acc_addr <= bmr_pkg::VEC_AREA_TOP);
      acc_write_q     <= acc_req && acc_write &&
                         !(!mode[bmr_pkg::MODE_W32_BIT] &&
                           acc_addr <= bmr_pkg::VEC_AREA_TOP) &&
                         !((config_q == bmr_pkg::CFG_NARROW) &&
                           acc_addr[31:bmr_pkg::NARROW_ADDR_W] != 6'h00);
    end
  end

  // Sticky access events; a new event beats a clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      event_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (reg_wr && reg_addr == bmr_pkg::OFS_EVENT && reg_wdata[i]) begin
          event_q[i] <= 1'b0;
        end
      end
      if (acc_vec_abort_q) begin
        event_q[bmr_pkg::EVT_VEC_ABORT] <= 1'b1;
      end
      if (acc_addr_exc_q) begin
        event_q[bmr_pkg::EVT_ADDR_EXC] <= 1'b1;
      end
    end
  end

  // Register port read data; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == bmr_pkg::OFS_CONFIG) begin
        reg_rdata_q <= {30'h00000000, config_q};
      end else if (reg_addr == bmr_pkg::OFS_STATUS) begin
        reg_rdata_q <= status_q;
      end else if (reg_addr == bmr_pkg::OFS_PC) begin
        reg_rdata_q <= pc_q;
      end else if (reg_addr == bmr_pkg::OFS_SAVED) begin
        reg_rdata_q <= cur_saved_ok ? saved_q[3'(cur_bank - 3'h1)] : 32'h00000000;
      end else if (reg_addr == bmr_pkg::OFS_EVENT) begin
        reg_rdata_q <= {30'h00000000, event_q};
      end else begin
        reg_rdata_q <= 32'h00000000;
      end
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// file: logic/bmr_pkg.sv
// Constants and types shared by the banked mode register file
package bmr_pkg;

  // Processor configurations held in the configuration register
  localparam logic [1:0] CFG_NARROW = 2'h0;
  localparam logic [1:0] CFG_MIXED  = 2'h1;
  localparam logic [1:0] CFG_FULL   = 2'h2;
  localparam logic [1:0] CFG_RESET  = CFG_NARROW;

  // Mode codes; bit 4 set marks a 32-bit mode
  localparam logic [4:0] MODE_USR26 = 5'h00;
  localparam logic [4:0] MODE_FIQ26 = 5'h01;
  localparam logic [4:0] MODE_IRQ26 = 5'h02;
  localparam logic [4:0] MODE_SVC26 = 5'h03;
  localparam logic [4:0] MODE_USR   = 5'h10;
  localparam logic [4:0] MODE_FIQ   = 5'h11;
  localparam logic [4:0] MODE_IRQ   = 5'h12;
  localparam logic [4:0] MODE_SVC   = 5'h13;
  localparam logic [4:0] MODE_ABT   = 5'h17;
  localparam logic [4:0] MODE_UND   = 5'h1b;
  localparam int         MODE_W32_BIT = 4;

  // Status word field positions
  localparam int STAT_FLAGS_HI = 31;
  localparam int STAT_FLAGS_LO = 28;
  localparam int STAT_IRQ_MASK = 7;
  localparam int STAT_FIQ_MASK = 6;
  localparam int STAT_MODE_HI  = 4;
  localparam int STAT_MODE_LO  = 0;
  localparam logic [31:0] STAT_RESET = 32'h000000c3;

  // Combined program-counter word of the 26-bit modes
  localparam int PCW_IRQ_MASK = 27;
  localparam int PCW_FIQ_MASK = 26;
  localparam int PCW_PC_HI    = 25;
  localparam int PCW_PC_LO    = 2;

  // Address checks
  localparam logic [31:0] VEC_AREA_TOP = 32'h0000001f;
  localparam int          NARROW_ADDR_W = 26;

  // Exception vectors
  localparam logic [31:0] VEC_UND  = 32'h00000004;
  localparam logic [31:0] VEC_SWI  = 32'h00000008;
  localparam logic [31:0] VEC_PABT = 32'h0000000c;
  localparam logic [31:0] VEC_DABT = 32'h00000010;
  localparam logic [31:0] VEC_ADDR = 32'h00000014;
  localparam logic [31:0] VEC_IRQ  = 32'h00000018;
  localparam logic [31:0] VEC_FIQ  = 32'h0000001c;
  localparam logic [31:0] PC_RESET = 32'h00000000;

  // Physical storage layout
  localparam int NUM_PHYS   = 30;
  localparam int FIQ_BASE   = 13;
  localparam int BANK_BASE  = 18;
  localparam int NUM_SAVED  = 5;

  // Register port offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_SAVED  = 8'h0c;
  localparam logic [7:0] OFS_EVENT  = 8'h10;
  localparam int EVT_VEC_ABORT = 0;
  localparam int EVT_ADDR_EXC  = 1;

  typedef enum logic [2:0] {
    EXC_FIQ, EXC_IRQ, EXC_SWI, EXC_PABT, EXC_DABT, EXC_UND, EXC_ADDR
  } bmr_exc_t;

endpackage

// file: dv/bmr_core_props.sv
// Port assertions for the banked mode register file
`timescale 1ns/1ps
`default_nettype none
module bmr_core_props (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              resetn,
  // Core inputs
  input wire logic [3:0]        rd_a_idx,
  input wire logic              wr_en,
  input wire logic              pc_wr_en,
  input wire logic              status_write_instr,
  input wire logic              exc_valid,
  input wire bmr_pkg::bmr_exc_t exc_kind,
  input wire logic              acc_req,
  input wire logic              acc_write,
  input wire logic [31:0]       acc_addr,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  // Outputs
  input wire logic [31:0]       rd_a_q,
  input wire logic              acc_write_q,
  input wire logic              acc_addr_exc_q,
  input wire logic              acc_vec_abort_q,
  input wire logic [31:0]       pc_q,
  input wire logic [31:0]       status_q,
  input wire logic [1:0]        config_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic full;
  logic quiet;
  assign full  = config_q == bmr_pkg::CFG_FULL;
  // No state update in this cycle, so next-cycle views stay put
  assign quiet = !exc_valid && !status_write_instr && !reg_wr && !wr_en && !pc_wr_en;

  AST_RESET_STATE: assert property (
    $rose(resetn) |-> config_q == bmr_pkg::CFG_RESET && status_q == bmr_pkg::STAT_RESET)
    else $error("state after reset wrong");
  AST_NARROW_NO_W32: assert property (
    reg_wr && reg_addr == bmr_pkg::OFS_STATUS && config_q == bmr_pkg::CFG_NARROW
    && !status_q[4] && !exc_valid && !status_write_instr |=> !status_q[4])
    else $error("32-bit mode entered in narrow configuration");
  AST_ADDR_EXC_RAISE: assert property (
    acc_req && config_q == bmr_pkg::CFG_NARROW && acc_addr[31:26] != 6'h0 |=> acc_addr_exc_q)
    else $error("address exception missing");
  AST_ADDR_EXC_NONE: assert property (
    acc_req && config_q != bmr_pkg::CFG_NARROW |=> !acc_addr_exc_q)
    else $error("address exception outside narrow configuration");
  AST_VEC_WRITE: assert property (
    acc_req && acc_write && !status_q[4] && acc_addr <= bmr_pkg::VEC_AREA_TOP
    |=> acc_vec_abort_q && !acc_write_q)
    else $error("vector write not blocked");
  AST_EXC_TO_W32: assert property (
    exc_valid && full && exc_kind != bmr_pkg::EXC_ADDR |=> status_q[4] && status_q[7])
    else $error("exception did not enter a 32-bit mode");
  AST_UND_ENTRY: assert property (
    exc_valid && full && exc_kind == bmr_pkg::EXC_UND
    |=> status_q[4:0] == bmr_pkg::MODE_UND && pc_q == bmr_pkg::VEC_UND)
    else $error("undefined entry wrong");
  AST_ABT_ENTRY: assert property (
    exc_valid && full && exc_kind inside {bmr_pkg::EXC_PABT, bmr_pkg::EXC_DABT}
    |=> status_q[4:0] == bmr_pkg::MODE_ABT)
    else $error("abort entry wrong");
  AST_PC_WORD: assert property (
    quiet && rd_a_idx == 4'hf && !status_q[4]
    |=> rd_a_q[27:26] == status_q[7:6] && rd_a_q[25:2] == pc_q[25:2])
    else $error("combined pc word wrong");
  AST_CFG_RESERVED: assert property (
    reg_wr && reg_addr == bmr_pkg::OFS_CONFIG && reg_wdata[1:0] == 2'h3 |=> $stable(config_q))
    else $error("reserved configuration accepted");

  COV_FULL_EXC: cover property (exc_valid && full);
  COV_VEC_ABORT: cover property (acc_vec_abort_q);
  COV_ADDR_EXC: cover property (acc_addr_exc_q);
endmodule
`default_nettype wire

// file: dv/bmr_core_tb.sv
// Self-checking bench for the banked mode register file
`timescale 1ns/1ps
`default_nettype none
bind bmr_core bmr_core_props u_props (.sys_clk, .resetn, .rd_a_idx, .wr_en, .pc_wr_en,
  .status_write_instr, .exc_valid, .exc_kind, .acc_req, .acc_write, .acc_addr, .reg_addr,
  .reg_wdata, .reg_wr, .rd_a_q, .acc_write_q, .acc_addr_exc_q, .acc_vec_abort_q, .pc_q,
  .status_q, .config_q);
module bmr_core_tb;
  logic              sys_clk, resetn, wr_en, pc_wr_en, status_write_instr;
  logic              status_read_instr, status_use_saved, exc_valid, acc_req, acc_write;
  logic              reg_wr, reg_rd, acc_go_q, acc_write_q, acc_addr_exc_q, acc_vec_abort_q;
  logic [3:0]        rd_a_idx, rd_b_idx, wr_idx;
  logic [7:0]        reg_addr;
  logic [1:0]        config_q;
  logic [31:0]       wr_data, pc_wr_data, status_wr_data, exc_ret_pc, acc_addr, reg_wdata;
  logic [31:0]       rd_a_q, rd_b_q, status_rd_q, reg_rdata_q, pc_q, status_q;
  bmr_pkg::bmr_exc_t exc_kind;
  logic [4:0]        modes [10];
  logic [4:0]        xm [7];
  logic [31:0]       xp [7];
  int                fails, checked;

  bmr_core dut (.sys_clk, .resetn, .rd_a_idx, .rd_b_idx, .rd_a_q, .rd_b_q, .wr_en, .wr_idx,
    .wr_data, .pc_wr_en, .pc_wr_data, .status_write_instr, .status_read_instr,
    .status_use_saved, .status_wr_data, .status_rd_q, .exc_valid, .exc_kind, .exc_ret_pc,
    .acc_req, .acc_write, .acc_addr, .acc_go_q, .acc_write_q, .acc_addr_exc_q,
    .acc_vec_abort_q, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .pc_q,
    .status_q, .config_q);

  always #25 sys_clk = ~sys_clk;

  // Tasks return 1 ns after their last edge; chk copies its values on entry
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rw(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rr(logic [7:0] a, logic [31:0] e, string w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(w, e, reg_rdata_q);
  endtask
  task automatic wreg(logic [3:0] i, logic [31:0] d);
    @(posedge sys_clk);
    wr_idx  <= i;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
    #1;
  endtask
  task automatic pcw(logic [31:0] d);
    @(posedge sys_clk);
    pc_wr_data <= d;
    pc_wr_en   <= 1'b1;
    @(posedge sys_clk);
    pc_wr_en   <= 1'b0;
    #1;
  endtask
  task automatic rd2(logic [3:0] a, logic [3:0] b, logic [31:0] ea, logic [31:0] eb);
    @(posedge sys_clk);
    rd_a_idx <= a;
    rd_b_idx <= b;
    @(posedge sys_clk);
    #1;
    chk("read port a", ea, rd_a_q);
    chk("read port b", eb, rd_b_q);
  endtask
  task automatic exc(bmr_pkg::bmr_exc_t k, logic [31:0] r);
    @(posedge sys_clk);
    exc_kind   <= k;
    exc_ret_pc <= r;
    exc_valid  <= 1'b1;
    @(posedge sys_clk);
    exc_valid  <= 1'b0;
    #1;
  endtask
  task automatic acc(logic w, logic [31:0] a, logic [2:0] e);
    @(posedge sys_clk);
    acc_write <= w;
    acc_addr  <= a;
    acc_req   <= 1'b1;
    @(posedge sys_clk);
    acc_req   <= 1'b0;
    #1;
    chk("access flags", {28'h0, 1'b1, e},
      {28'h0, acc_go_q, acc_write_q, acc_addr_exc_q, acc_vec_abort_q});
  endtask
  task automatic sins(logic wr, logic sv, logic [31:0] d);
    @(posedge sys_clk);
    status_use_saved   <= sv;
    status_wr_data     <= d;
    status_write_instr <= wr;
    status_read_instr  <= !wr;
    @(posedge sys_clk);
    status_write_instr <= 1'b0;
    status_read_instr  <= 1'b0;
    #1;
  endtask
  // Software interrupt first, so even a user mode can be left
  task automatic setm(logic [4:0] m);
    exc(bmr_pkg::EXC_SWI, 32'h0);
    rw(bmr_pkg::OFS_STATUS, {24'h0, 3'h6, m});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    {wr_en, pc_wr_en, status_write_instr, status_read_instr, status_use_saved} = '0;
    {exc_valid, acc_req, acc_write, reg_wr, reg_rd} = '0;
    {rd_a_idx, rd_b_idx, wr_idx, reg_addr} = '0;
    {wr_data, pc_wr_data, status_wr_data, exc_ret_pc, acc_addr, reg_wdata} = '0;
    exc_kind = bmr_pkg::EXC_FIQ;
    modes = '{bmr_pkg::MODE_FIQ26, bmr_pkg::MODE_IRQ26, bmr_pkg::MODE_SVC26,
      bmr_pkg::MODE_FIQ, bmr_pkg::MODE_IRQ, bmr_pkg::MODE_ABT, bmr_pkg::MODE_UND,
      bmr_pkg::MODE_SVC, bmr_pkg::MODE_USR, bmr_pkg::MODE_USR26};
    xm = '{bmr_pkg::MODE_FIQ, bmr_pkg::MODE_IRQ, bmr_pkg::MODE_SVC, bmr_pkg::MODE_ABT,
      bmr_pkg::MODE_ABT, bmr_pkg::MODE_UND, bmr_pkg::MODE_USR26};
    xp = '{bmr_pkg::VEC_FIQ, bmr_pkg::VEC_IRQ, bmr_pkg::VEC_SWI, bmr_pkg::VEC_PABT,
      bmr_pkg::VEC_DABT, bmr_pkg::VEC_UND, bmr_pkg::VEC_SWI};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    chk("config", 32'h0, {30'h0, config_q});
    chk("status", bmr_pkg::STAT_RESET, status_q);
    rr(8'h20, 32'h0, "unmapped read");
    rw(bmr_pkg::OFS_STATUS, 32'hf00000d3);
    chk("narrow status", 32'hf00000c3, status_q);
    wreg(4'h0, 32'ha5a50f0f);
    pcw(32'h01234568);
    rd2(4'hf, 4'h0, {4'hf, 2'h3, 24'h48d15a, 2'h3}, 32'ha5a50f0f);
    acc(1'b0, 32'h04000000, 3'b010);
    acc(1'b0, 32'h03fffffc, 3'b000);
    acc(1'b1, 32'h0000001f, 3'b001);
    acc(1'b1, 32'h00000020, 3'b100);
    rr(bmr_pkg::OFS_EVENT, 32'h3, "events");
    rw(bmr_pkg::OFS_EVENT, 32'h3);
    rr(bmr_pkg::OFS_EVENT, 32'h0, "events cleared");
    exc(bmr_pkg::EXC_ADDR, 32'h40);
    chk("trap pc", bmr_pkg::VEC_ADDR, pc_q);
    rw(bmr_pkg::OFS_CONFIG, 32'h1);
    acc(1'b0, 32'h04000000, 3'b000);
    rw(bmr_pkg::OFS_CONFIG, 32'h2);
    rw(bmr_pkg::OFS_CONFIG, 32'h3);
    rr(bmr_pkg::OFS_CONFIG, 32'h2, "config");
    acc(1'b0, 32'h04000000, 3'b000);
    foreach (modes[i]) begin
      setm(modes[i]);
      chk("mode", 32'hc0 | modes[i], status_q);
      wreg(4'hd, 32'h13000000 | modes[i][3:0]);
      wreg(4'h8, 32'h08000000 | (modes[i][3:0] == 4'h1));
    end
    // Mode code low bits name the bank, so they tag each copy
    foreach (modes[i]) begin
      setm(modes[i]);
      rd2(4'hd, 4'h8, 32'h13000000 | modes[i][3:0],
        32'h08000000 | (modes[i][3:0] == 4'h1));
    end
    for (int k = 0; k < 7; k++) begin
      setm(bmr_pkg::MODE_USR26);
      exc(bmr_pkg::bmr_exc_t'(k), 32'h1000 + k);
      chk("entry status", 32'hc0 | xm[k], status_q);
      chk("entry pc", xp[k], pc_q);
      if (k < 6) begin
        rd2(4'he, 4'he, 32'h1000 + k, 32'h1000 + k);
        rr(bmr_pkg::OFS_SAVED, 32'hc0, "saved word");
      end
    end
    setm(bmr_pkg::MODE_SVC26);
    sins(1'b0, 1'b1, 32'h0);
    chk("saved read", 32'hc0, status_rd_q);
    sins(1'b0, 1'b0, 32'h0);
    chk("status read", 32'hc3, status_rd_q);
    sins(1'b1, 1'b0, 32'hd3);
    chk("status write", 32'hd3, status_q);
    sins(1'b1, 1'b1, 32'h200000d0);
    rr(bmr_pkg::OFS_SAVED, 32'h200000d0, "saved write");
    rw(bmr_pkg::OFS_PC, 32'h00000100);
    rr(bmr_pkg::OFS_PC, 32'h00000100, "pc port write");
    wreg(4'hf, 32'h00000200);
    rr(bmr_pkg::OFS_PC, 32'h00000200, "pc register write");
    pcw(32'hfedcba98);
    rd2(4'hf, 4'hf, 32'hfedcba98, 32'hfedcba98);
    conclude();
  end
endmodule
`default_nettype wire
